/* csalu_top.sv */
// Command stream ALU: decodes one math micro-instruction per accepted dword.
// Assumes instructions come only from the math_command path of the streamer
// front end, and that the memory port returns one response per read/write.
`timescale 1ns/1ps

module csalu_top #(
    parameter int MAX_OUTSTANDING = 15
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic instr_valid,
    input wire csalu_pkg::csalu_instr_s instr,
    output logic instr_ready,
    input wire csalu_pkg::csalu_mmio_req_s mmio_req,
    output logic [63:0] mmio_rdata,
    input wire logic [3:0] mmio_rd_index,
    output csalu_pkg::csalu_mem_req_s mem_req,
    input wire logic mem_req_ready,
    input wire csalu_pkg::csalu_mem_rsp_s mem_rsp,
    output logic [63:0] acc_out,
    output logic zero_flag_out,
    output logic carry_flag_out
);
    import csalu_pkg::*;

    initial begin
        if (MAX_OUTSTANDING < 1 || MAX_OUTSTANDING > 255) begin
            $error("MAX_OUTSTANDING out of range");
        end
    end

    // Reset release through two flops
    logic rst_meta_n;
    logic rst_n;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    logic [63:0] general_register [CSALU_NUM_GPR];
    logic [63:0] operand_a;
    logic [63:0] operand_b;
    logic [63:0] result_accumulator;
    logic zero_flag;
    logic carry_flag;
    logic [CSALU_NUM_GPR-1:0] pending;
    logic [7:0] rd_count;
    logic [7:0] wr_count;

    // Decode
    wire [11:0] opc = instr.opcode;
    wire [9:0] op1 = instr.operand1;
    wire [9:0] op2 = instr.operand2;
    wire [1:0] pfx = opc[CSALU_PFX_MSB:CSALU_PFX_LSB];
    wire [2:0] cls = opc[CSALU_CLS_MSB:CSALU_CLS_LSB];
    wire [6:0] sub = opc[CSALU_SUB_MSB:CSALU_SUB_LSB];
    wire op1_is_gpr = op1[9:4] == 6'h00;
    wire op2_is_gpr = op2[9:4] == 6'h00;
    wire [3:0] gi1 = op1[3:0];
    wire [3:0] gi2 = op2[3:0];
    wire is_cmp = cls == CSALU_CLS_COMPUTE && pfx == CSALU_PFX_REGULAR
        && sub <= 7'h07;
    wire is_fetch = opc == CSALU_OP_FETCH || opc == CSALU_OP_FETCH_INV;
    wire is_fill = opc == CSALU_OP_FILL_ZERO || opc == CSALU_OP_FILL_ONES;
    wire is_mfetch = opc == CSALU_OP_MEM_FETCH && op1_is_gpr;
    wire is_wb = (opc == CSALU_OP_WRBACK || opc == CSALU_OP_WRBACK_INV)
        && op1_is_gpr;
    wire is_mwb = opc == CSALU_OP_MEM_WRBACK && op2_is_gpr;
    wire op1_opab = op1 == CSALU_SEL_OPA || op1 == CSALU_SEL_OPB;

    // Hazard interlock on the registers touched
    wire haz1 = (is_mfetch || is_wb) && pending[gi1];
    wire haz2 = (is_fetch && op2_is_gpr || is_mwb) && pending[gi2];
    wire need_mem = is_mfetch || is_mwb;
    wire cnt_full = (rd_count + wr_count) >= 8'(MAX_OUTSTANDING);
    wire barrier_rd = opc == CSALU_OP_RD_BARRIER && rd_count != 8'h00;
    wire barrier_wr = opc == CSALU_OP_WR_BARRIER && wr_count != 8'h00;
    wire mem_stall = need_mem && (cnt_full || (mem_req.valid
        && !mem_req_ready));
    wire stall = haz1 || haz2 || barrier_rd || barrier_wr || mem_stall;
    wire go = clk_en && instr_valid && instr_ready;

    // Shift amount rounding
    // Whole operand_b is judged, so huge amounts still shift by 32
    logic [5:0] shamt;
    always_comb begin
        shamt = 6'd0;
        if (operand_b >= 64'd32) begin
            shamt = 6'd32;
        end else if (operand_b >= 64'd16) begin
            shamt = 6'd16;
        end else if (operand_b >= 64'd8) begin
            shamt = 6'd8;
        end else if (operand_b >= 64'd4) begin
            shamt = 6'd4;
        end else if (operand_b >= 64'd2) begin
            shamt = 6'd2;
        end else if (operand_b == 64'd1) begin
            shamt = 6'd1;
        end
    end

    // Compute stage, all 64 bits
    wire [64:0] sum = {1'b0, operand_a} + {1'b0, operand_b};
    wire [64:0] diff = {1'b0, operand_a} - {1'b0, operand_b};
    logic [63:0] next_acc;
    logic next_carry;
    always_comb begin
        next_carry = 1'b0;
        case (opc)
            CSALU_OP_ADD: begin
                next_acc = sum[63:0];
                next_carry = sum[64];
            end
            CSALU_OP_SUB: begin
                next_acc = diff[63:0];
                next_carry = diff[64];
            end
            CSALU_OP_AND: next_acc = operand_a & operand_b;
            CSALU_OP_OR: next_acc = operand_a | operand_b;
            CSALU_OP_XOR: next_acc = operand_a ^ operand_b;
            CSALU_OP_SHL: next_acc = operand_a << shamt;
            CSALU_OP_SHR: next_acc = operand_a >> shamt;
            CSALU_OP_SAR: next_acc = $signed(operand_a) >>> shamt;
            default: next_acc = result_accumulator;
        endcase
    end
    wire next_zero = next_acc == 64'h0;

    // Fetch and writeback sources
    wire [63:0] src_gpr = general_register[gi2];
    logic [63:0] next_opnd;
    always_comb begin
        case (opc)
            CSALU_OP_FETCH: next_opnd = src_gpr;
            CSALU_OP_FETCH_INV: next_opnd = ~src_gpr;
            CSALU_OP_FILL_ONES: next_opnd = ~64'h0;
            default: next_opnd = 64'h0;
        endcase
    end
    logic [63:0] wb_src;
    logic wb_ok;
    always_comb begin
        wb_ok = 1'b1;
        case (op2)
            CSALU_SEL_ACC: wb_src = result_accumulator;
            CSALU_SEL_ZF: wb_src = {64{zero_flag}};
            CSALU_SEL_CF: wb_src = {64{carry_flag}};
            default: begin
                wb_src = 64'h0;
                wb_ok = 1'b0;
            end
        endcase
    end
    wire [63:0] wb_val = pfx == CSALU_PFX_INVERT ? ~wb_src : wb_src;
    wire fetch_ok = op1_opab && (is_fill || op2_is_gpr);
    wire [63:0] mem_addr = {result_accumulator[63:3], 3'h0};

    wire rsp_rd = mem_rsp.valid && mem_rsp.is_read;
    wire rsp_wr = mem_rsp.valid && !mem_rsp.is_read;
    wire issue_rd = go && is_mfetch;
    wire issue_wr = go && is_mwb;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_ready <= 1'b0;
        end else if (clk_en) begin
            instr_ready <= !(instr_valid && instr_ready) || !stall;
        end
    end

    // Ready falls one cycle late; a held instruction re-evaluates stall.
    // Acceptance qualified again by stall so no hazard slips through.
    wire exec = go && !stall;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            operand_a <= CSALU_RST_DATA;
            operand_b <= CSALU_RST_DATA;
            result_accumulator <= CSALU_RST_DATA;
            zero_flag <= 1'b0;
            carry_flag <= 1'b0;
        end else if (exec) begin
            if ((is_fetch || is_fill) && fetch_ok) begin
                if (op1 == CSALU_SEL_OPA) begin
                    operand_a <= next_opnd;
                end else begin
                    operand_b <= next_opnd;
                end
            end
            if (is_cmp) begin
                result_accumulator <= next_acc;
                zero_flag <= next_zero;
                carry_flag <= next_carry;
            end
        end
    end

    // General registers: instruction, memory return, register port
    // Memory return is written last so it wins over both other writers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < CSALU_NUM_GPR; i++) begin
                general_register[i] <= CSALU_RST_DATA;
            end
        end else if (clk_en) begin
            if (mmio_req.valid && mmio_req.write) begin
                general_register[mmio_req.index] <= mmio_req.wdata;
            end
            if (exec && is_wb && wb_ok) begin
                general_register[gi1] <= wb_val;
            end
            if (rsp_rd) begin
                general_register[mem_rsp.tag] <= mem_rsp.rdata;
            end
        end
    end

    // Pending-data scoreboard; arrival and new issue may coincide
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= '0;
            rd_count <= 8'h00;
            wr_count <= 8'h00;
        end else if (clk_en) begin
            for (int i = 0; i < CSALU_NUM_GPR; i++) begin
                if (issue_rd && exec && gi1 == 4'(i)) begin
                    pending[i] <= 1'b1;
                end else if (rsp_rd && mem_rsp.tag == 4'(i)) begin
                    pending[i] <= 1'b0;
                end
            end
            rd_count <= rd_count + 8'(issue_rd && exec) - 8'(rsp_rd);
            wr_count <= wr_count + 8'(issue_wr && exec) - 8'(rsp_wr);
        end
    end

    // Memory request register, held until accepted
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req <= '0;
        end else if (clk_en) begin
            if (exec && need_mem) begin
                mem_req.valid <= 1'b1;
                mem_req.write <= is_mwb;
                mem_req.addr <= mem_addr;
                mem_req.wdata <= src_gpr;
                mem_req.tag <= gi1;
            end else if (mem_req_ready) begin
                mem_req.valid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mmio_rdata <= CSALU_RST_DATA;
            acc_out <= CSALU_RST_DATA;
            zero_flag_out <= 1'b0;
            carry_flag_out <= 1'b0;
        end else if (clk_en) begin
            mmio_rdata <= general_register[mmio_rd_index];
            acc_out <= result_accumulator;
            zero_flag_out <= zero_flag;
            carry_flag_out <= carry_flag;
        end
    end

    // Checks
    AST_SUB_ORDER: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && opc == CSALU_OP_SUB |=> result_accumulator ==
        $past(operand_a) - $past(operand_b))
        else $error("subtract order wrong");
    AST_ZERO_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && is_cmp |=> zero_flag == (result_accumulator == 64'h0))
        else $error("zero flag mismatch");
    AST_SHIFT_15: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && opc == CSALU_OP_SHL && operand_b == 64'd15
        |=> result_accumulator == $past(operand_a) << 8)
        else $error("shift 15 not by 8");
    AST_RD_FENCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && opc == CSALU_OP_RD_BARRIER |-> rd_count == 8'h00)
        else $error("read barrier passed early");
    AST_WR_FENCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && opc == CSALU_OP_WR_BARRIER |-> wr_count == 8'h00)
        else $error("write barrier passed early");
    AST_HAZARD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && is_fetch && op2_is_gpr |-> !pending[gi2])
        else $error("fetch read pending register");
    AST_NOOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && opc == CSALU_OP_NOOP |=> $stable(result_accumulator)
        && $stable(operand_a) && $stable(operand_b))
        else $error("no-op changed state");
    AST_ALIGN: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mem_req.valid |-> mem_req.addr[2:0] == 3'h0)
        else $error("memory address not aligned");
    AST_FLAG_WB: assert property (@(posedge ref_clk) disable iff (!rst_n)
        exec && opc == CSALU_OP_WRBACK && op2 == CSALU_SEL_CF && op1_is_gpr
        && !(clk_en && mmio_req.valid && mmio_req.write)
        && !rsp_rd |=> general_register[$past(gi1)] ==
        {64{$past(carry_flag)}})
        else $error("flag not replicated");
    AST_OPND_SRC: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        $changed(operand_a) || $changed(operand_b)
        |-> $past(exec && (is_fetch || is_fill)))
        else $error("operand changed without fetch");
    AST_MEM_HOLD: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        mem_req.valid && !mem_req_ready |=> $stable(mem_req))
        else $error("memory request changed before acceptance");
    AST_WB_HAZARD: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        exec && (is_wb || is_mfetch) |-> !pending[gi1])
        else $error("write to register awaiting memory data");
endmodule

/* csalu_pkg.sv */
// Package for the command stream ALU: opcode, operand and field constants.
// Assumes a single 250 MHz engine clock domain.
package csalu_pkg;

    localparam int CSALU_DATA_W = 64;
    localparam int CSALU_NUM_GPR = 16;

    // Instruction dword layout
    localparam int CSALU_OPC_MSB = 31;
    localparam int CSALU_OPC_LSB = 20;
    localparam int CSALU_OP1_MSB = 19;
    localparam int CSALU_OP1_LSB = 10;
    localparam int CSALU_OP2_MSB = 9;
    localparam int CSALU_OP2_LSB = 0;

    // Opcode sub-fields
    localparam int CSALU_PFX_MSB = 11;
    localparam int CSALU_PFX_LSB = 10;
    localparam int CSALU_CLS_MSB = 9;
    localparam int CSALU_CLS_LSB = 7;
    localparam int CSALU_SUB_MSB = 6;
    localparam int CSALU_SUB_LSB = 0;

    localparam logic [1:0] CSALU_PFX_REGULAR = 2'h0;
    localparam logic [1:0] CSALU_PFX_INVERT = 2'h1;
    localparam logic [2:0] CSALU_CLS_NOOP = 3'h0;
    localparam logic [2:0] CSALU_CLS_FETCH = 3'h1;
    localparam logic [2:0] CSALU_CLS_COMPUTE = 3'h2;
    localparam logic [2:0] CSALU_CLS_WRBACK = 3'h3;

    // Full opcodes
    localparam logic [11:0] CSALU_OP_NOOP = 12'h000;
    localparam logic [11:0] CSALU_OP_RD_BARRIER = 12'h001;
    localparam logic [11:0] CSALU_OP_WR_BARRIER = 12'h002;
    localparam logic [11:0] CSALU_OP_FETCH = 12'h080;
    localparam logic [11:0] CSALU_OP_FETCH_INV = 12'h480;
    localparam logic [11:0] CSALU_OP_FILL_ZERO = 12'h081;
    localparam logic [11:0] CSALU_OP_FILL_ONES = 12'h481;
    localparam logic [11:0] CSALU_OP_MEM_FETCH = 12'h082;
    localparam logic [11:0] CSALU_OP_ADD = 12'h100;
    localparam logic [11:0] CSALU_OP_SUB = 12'h101;
    localparam logic [11:0] CSALU_OP_AND = 12'h102;
    localparam logic [11:0] CSALU_OP_OR = 12'h103;
    localparam logic [11:0] CSALU_OP_XOR = 12'h104;
    localparam logic [11:0] CSALU_OP_SHL = 12'h105;
    localparam logic [11:0] CSALU_OP_SHR = 12'h106;
    localparam logic [11:0] CSALU_OP_SAR = 12'h107;
    localparam logic [11:0] CSALU_OP_WRBACK = 12'h180;
    localparam logic [11:0] CSALU_OP_WRBACK_INV = 12'h580;
    localparam logic [11:0] CSALU_OP_MEM_WRBACK = 12'h181;

    // Operand encodings
    localparam logic [9:0] CSALU_SEL_OPA = 10'h020;
    localparam logic [9:0] CSALU_SEL_OPB = 10'h021;
    localparam logic [9:0] CSALU_SEL_ACC = 10'h031;
    localparam logic [9:0] CSALU_SEL_ZF = 10'h032;
    localparam logic [9:0] CSALU_SEL_CF = 10'h033;

    // Reset values
    localparam logic [63:0] CSALU_RST_DATA = 64'h0000000000000000;

    typedef struct packed {
        logic [11:0] opcode;
        logic [9:0] operand1;
        logic [9:0] operand2;
    } csalu_instr_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [63:0] addr;
        logic [63:0] wdata;
        logic [3:0] tag;
    } csalu_mem_req_s;

    typedef struct packed {
        logic valid;
        logic is_read;
        logic [3:0] tag;
        logic [63:0] rdata;
    } csalu_mem_rsp_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] index;
        logic [63:0] wdata;
    } csalu_mmio_req_s;

endpackage

/* csalu_mem_model.sv */
// Behavioural memory behind the ALU's indirect load/store port.
// Assumes one request per valid/ready handshake; the tag is echoed back.
`timescale 1ns/1ps
module csalu_mem_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire csalu_pkg::csalu_mem_req_s mem_req,
    output logic mem_req_ready = 1'b0,
    output csalu_pkg::csalu_mem_rsp_s mem_rsp = '0
);
    import csalu_pkg::*;
    logic [63:0] mem [logic [63:0]];
    csalu_mem_rsp_s pend [$];
    int due [$];
    int cyc = 0;
    csalu_mem_rsp_s r;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend.delete();
            due.delete();
            mem_rsp <= '0;
            mem_req_ready <= 1'b0;
        end else begin
            cyc = cyc + 1;
            // Slow mode refuses two cycles in three to exercise stalls
            mem_req_ready <= !slow || (cyc % 3 == 0);
            if (mem_req.valid && mem_req_ready) begin
                r.valid = 1'b1;
                r.is_read = !mem_req.write;
                r.tag = mem_req.tag;
                if (mem_req.write)
                    mem[mem_req.addr] = mem_req.wdata;
                // Unwritten places answer a pattern, never a lucky zero
                r.rdata = mem.exists(mem_req.addr) ? mem[mem_req.addr]
                                                   : ~mem_req.addr;
                pend.push_back(r);
                due.push_back(cyc + (slow ? 12 : 2));
            end
            if (pend.size() > 0 && due[0] <= cyc) begin
                mem_rsp <= pend.pop_front();
                void'(due.pop_front());
            end else begin
                // Released lines keep changing so stale data cannot match
                mem_rsp <= {1'b0, ~mem_rsp.is_read, ~mem_rsp.tag, {2{cyc}}};
            end
        end
    end
endmodule

/* tb.sv */
// Self-checking bench for the command stream ALU.
// Assumes the memory model answers every request; clk_en stays high.
`timescale 1ns/1ps
module tb;
    import csalu_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic instr_valid = 1'b0;
    csalu_instr_s instr = '0;
    logic instr_ready;
    csalu_mmio_req_s mmio_req = '0;
    logic [63:0] mmio_rdata;
    logic [3:0] mmio_rd_index = 4'h0;
    csalu_mem_req_s mem_req;
    logic mem_req_ready;
    csalu_mem_rsp_s mem_rsp;
    logic [63:0] acc_out;
    logic zero_flag_out;
    logic carry_flag_out;
    logic slow = 1'b0;
    logic [63:0] wr_addr = '0;
    logic [63:0] wr_data = '0;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int n_wr = 0;
    int n_wrsp = 0;
    localparam logic [63:0] D1 = 64'hA5A5_0000_1111_2222;
    localparam logic [9:0] ACC = CSALU_SEL_ACC;

    csalu_top #(.MAX_OUTSTANDING(2)) DUT (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
        .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
        .mmio_req(mmio_req), .mmio_rdata(mmio_rdata),
        .mmio_rd_index(mmio_rd_index), .mem_req(mem_req),
        .mem_req_ready(mem_req_ready), .mem_rsp(mem_rsp), .acc_out(acc_out),
        .zero_flag_out(zero_flag_out), .carry_flag_out(carry_flag_out));

    csalu_mem_model mem_model (
        .ref_clk(ref_clk), .reset_n(reset_n), .slow(slow),
        .mem_req(mem_req), .mem_req_ready(mem_req_ready), .mem_rsp(mem_rsp));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // First write after n_wr is cleared is captured for comparison
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (mem_req.valid === 1'b1 && mem_req_ready === 1'b1 &&
            mem_req.write === 1'b1) begin
            if (n_wr == 0) begin
                wr_addr = mem_req.addr;
                wr_data = mem_req.wdata;
            end
            n_wr = n_wr + 1;
        end
        if (mem_rsp.valid === 1'b1 && mem_rsp.is_read === 1'b0) begin
            n_wrsp = n_wrsp + 1;
        end
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic idle(input int n);
        instr_valid = 1'b0;
        repeat (n) step();
    endtask

    // Leaves valid high so the next call can follow back to back.
    // Taken at an edge that finds ready high and leaves it high; a stall
    // drops ready, so the dword is held until the unit really takes it.
    task automatic put(input logic [11:0] op, input logic [9:0] o1,
                       input logic [9:0] o2, input int hold);
        int k;
        logic seen;
        k = 0;
        seen = 1'b0;
        instr = '{opcode: op, operand1: o1, operand2: o2};
        instr_valid = 1'b1;
        while (!seen && k < 100) begin
            seen = instr_ready === 1'b1;
            step();
            seen = seen && instr_ready === 1'b1;
            k++;
        end
        chk({63'h0, seen}, 64'h1);
        repeat (hold - 1) step();
    endtask

    task automatic gwr(input logic [3:0] i, input logic [63:0] d);
        mmio_req = '{valid: 1'b1, write: 1'b1, index: i, wdata: d};
        step();
        mmio_req.valid = 1'b0;
        step();
    endtask

    task automatic chk_gpr(input logic [3:0] i, input logic [63:0] exp);
        mmio_rd_index = i;
        step();
        step();
        chk(mmio_rdata, exp);
    endtask

    task automatic wait_rsp();
        int k;
        k = 0;
        while (mem_rsp.valid !== 1'b1 && k < 100) begin
            step();
            k++;
        end
        chk({63'h0, mem_rsp.valid}, 64'h1);
    endtask

    task automatic run(input logic [11:0] fa, input logic [9:0] ra,
                       input logic [11:0] fb, input logic [9:0] rb,
                       input logic [11:0] op);
        put(fa, CSALU_SEL_OPA, ra, 1);
        put(fb, CSALU_SEL_OPB, rb, 1);
        put(op, 10'h000, 10'h000, 1);
        idle(3);
    endtask

    function automatic logic [64:0] model(input logic [11:0] op,
                                          input logic [63:0] a, b);
        int s;
        s = b >= 32 ? 32 : b >= 16 ? 16 : b >= 8 ? 8 : b >= 4 ? 4 :
            b >= 2 ? 2 : b >= 1 ? 1 : 0;
        case (op)
            CSALU_OP_ADD: return {1'b0, a} + {1'b0, b};
            CSALU_OP_SUB: return {1'b0, a} - {1'b0, b};
            CSALU_OP_AND: return {1'b0, a & b};
            CSALU_OP_OR: return {1'b0, a | b};
            CSALU_OP_XOR: return {1'b0, a ^ b};
            CSALU_OP_SHL: return {1'b0, a << s};
            CSALU_OP_SHR: return {1'b0, a >> s};
            default: return {1'b0, 64'($signed(a) >>> s)};
        endcase
    endfunction

    task automatic t_compute();
        logic [11:0] op [13] = '{CSALU_OP_ADD, CSALU_OP_ADD, CSALU_OP_SUB,
            CSALU_OP_SUB, CSALU_OP_AND, CSALU_OP_OR, CSALU_OP_XOR,
            CSALU_OP_SHL, CSALU_OP_SHR, CSALU_OP_SAR, CSALU_OP_SHL,
            CSALU_OP_SHR, CSALU_OP_SAR};
        logic [63:0] a [13] = '{64'hFFFF_FFFF_FFFF_FFFF,
            64'h8000_0000_0000_0000, 64'h5, 64'h3, 64'hF0F0_F0F0_F0F0_F0F0,
            64'hF0F0_F0F0_F0F0_F0F0, 64'hF0F0_F0F0_F0F0_F0F0, 64'h81,
            64'h8000_0000_0000_0001, 64'h8000_0000_0000_0000,
            64'h0123_4567_89AB_CDEF, 64'hFEDC_BA98_7654_3210,
            64'h7000_0000_0000_0000};
        logic [63:0] b [13] = '{64'h1, 64'h7FFF_FFFF_FFFF_FFFF, 64'h3, 64'h5,
            64'h3C3C_3C3C_3C3C_3C3C, 64'h3C3C_3C3C_3C3C_3C3C,
            64'hF0F0_F0F0_F0F0_F0F0, 64'hF, 64'h21, 64'h2, 64'h0, 64'h1F,
            64'h5};
        logic [64:0] e;
        for (int i = 0; i < 13; i++) begin
            gwr(4'h0, a[i]);
            gwr(4'h1, b[i]);
            run(CSALU_OP_FETCH, 10'h000, CSALU_OP_FETCH, 10'h001, op[i]);
            e = model(op[i], a[i], b[i]);
            chk(acc_out, e[63:0]);
            chk({63'h0, zero_flag_out}, {63'h0, e[63:0] == 64'h0});
            if (i < 4)
                chk({63'h0, carry_flag_out}, {63'h0, e[64]});
        end
        $display("compute test done");
    endtask

    task automatic t_fill_wb();
        logic [11:0] wop [6] = '{CSALU_OP_WRBACK, CSALU_OP_WRBACK,
            CSALU_OP_WRBACK, CSALU_OP_WRBACK_INV, CSALU_OP_WRBACK_INV,
            CSALU_OP_WRBACK_INV};
        logic [9:0] src [6] = '{ACC, CSALU_SEL_ZF, CSALU_SEL_CF, ACC,
            CSALU_SEL_ZF, CSALU_SEL_CF};
        logic [63:0] exp [6] = '{64'h1, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF,
            64'hFFFF_FFFF_FFFF_FFFE, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0};
        gwr(4'h2, 64'h0F1E_2D3C_4B5A_6978);
        run(CSALU_OP_FETCH_INV, 10'h002, CSALU_OP_FILL_ZERO, 10'h0,
            CSALU_OP_OR);
        chk(acc_out, 64'hF0E1_D2C3_B4A5_9687);
        run(CSALU_OP_FILL_ONES, 10'h0, CSALU_OP_FILL_ZERO, 10'h0,
            CSALU_OP_ADD);
        chk(acc_out, 64'hFFFF_FFFF_FFFF_FFFF);
        run(CSALU_OP_FILL_ZERO, 10'h0, CSALU_OP_FILL_ONES, 10'h0,
            CSALU_OP_SUB);
        chk(acc_out, 64'h1);
        chk({63'h0, carry_flag_out}, 64'h1);
        for (int i = 0; i < 6; i++)
            put(wop[i], 10'(4 + i), src[i], 1);
        idle(2);
        for (int i = 0; i < 6; i++)
            chk_gpr(4'(4 + i), exp[i]);
        $display("fill and writeback test done");
    endtask

    task automatic t_undef();
        logic [11:0] u [8] = '{CSALU_OP_NOOP, 12'h003, 12'h083, 12'h108,
            12'h182, 12'h200, 12'h880, 12'hFFF};
        for (int i = 0; i < 8; i++)
            put(u[i], 10'h004, CSALU_SEL_OPB, 1);
        idle(3);
        chk(acc_out, 64'h1);
        chk({62'h0, zero_flag_out, carry_flag_out}, 64'h1);
        chk_gpr(4'h4, 64'h1);
        put(CSALU_OP_ADD, 10'h0, 10'h0, 1);
        idle(3);
        chk(acc_out, 64'hFFFF_FFFF_FFFF_FFFF);
        $display("no-op test done");
    endtask

    task automatic t_memory();
        gwr(4'h8, 64'h1005);
        gwr(4'h9, D1);
        run(CSALU_OP_FETCH, 10'h008, CSALU_OP_FILL_ZERO, 10'h0, CSALU_OP_ADD);
        n_wr = 0;
        put(CSALU_OP_MEM_WRBACK, ACC, 10'h009, 1);
        idle(8);
        chk(64'(n_wr), 64'h1);
        chk(wr_addr, 64'h1000);
        chk(wr_data, D1);
        put(CSALU_OP_MEM_FETCH, 10'h00A, ACC, 1);
        idle(8);
        chk_gpr(4'hA, D1);
        // Held until the fill returns; a hazard-blind unit stores R11 early
        slow = 1'b1;
        gwr(4'hB, 64'h1111_2222_3333_4444);
        n_wr = 0;
        put(CSALU_OP_MEM_FETCH, 10'h00B, ACC, 1);
        put(CSALU_OP_MEM_WRBACK, ACC, 10'h00B, 1);
        wait_rsp();
        step();
        step();
        idle(40);
        chk(wr_data, D1);
        chk_gpr(4'hB, D1);
        $display("memory test done");
    endtask

    task automatic t_barrier();
        // Barrier must already have waited out the slow memory
        put(CSALU_OP_MEM_FETCH, 10'h00C, ACC, 1);
        put(CSALU_OP_RD_BARRIER, 10'h0, 10'h0, 1);
        chk_gpr(4'hC, D1);
        idle(3);
        chk(acc_out, 64'h1005);
        n_wr = 0;
        n_wrsp = 0;
        put(CSALU_OP_MEM_WRBACK, ACC, 10'h008, 1);
        put(CSALU_OP_WR_BARRIER, 10'h0, 10'h0, 1);
        chk(64'(n_wrsp), 64'h1);
        idle(3);
        chk(64'(n_wr), 64'h1);
        chk(acc_out, 64'h1005);
        slow = 1'b0;
        $display("barrier test done");
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        #1;
        chk({63'h0, instr_ready}, 64'h0);
        chk(acc_out, 64'h0);
        reset_n = 1'b1;
        // Internal reset lets go two edges later; ready follows one after
        repeat (3) step();
        chk({63'h0, instr_ready}, 64'h1);
        t_compute();
        t_fill_wb();
        t_undef();
        t_memory();
        t_barrier();
        finish_test();
    end
endmodule
